// *** rtl/bsw_pkg.sv ***
// constants, register map and types for the backup switchover and clock output control
// ============================================================================
package bsw_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CLKCFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  // config register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_IRQEN_BIT = 2;
  localparam int CFG_CHG_LSB = 4;
  localparam int CFG_VLF_BIT = 6;
  localparam int CFG_IRQ_CLOCK_PATH_ENABLE_BIT = 7;
  localparam int CFG_CLKMASK_LSB = 8;
  localparam int CFG_HALT_BIT = 14;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK = 32'h0000_7ff7;
  // clock config register fields
  localparam int CC_FD_LSB = 0;
  localparam int CC_OS_BIT = 2;
  localparam int CC_DIS_BIT = 3;
  localparam int CC_HFD_LSB = 4;
  localparam logic [31:0] CLKCFG_RESET = 32'h0000_0000;
  // flag register bits (write one to clear)
  localparam int FL_BSF_BIT = 0;
  localparam int FL_IRQ_CLOCK_PATH_FLAG_BIT = 1;
  // mode codes
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;
  localparam logic [1:0] CHG_OFF = 2'h0;
  localparam logic [1:0] FD_RAW = 2'h0;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int DEB_SHORT_MS = 1;
  localparam int DEB_LONG_MS = 1000;
  localparam int SETTLE_DIRECT_MS = 2;
  localparam int SETTLE_LEVEL_MS = 10;
  localparam int TICK_HZ = 1024;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int DEB_SHORT_TK = DEB_SHORT_MS * TICK_HZ / 1000;
  localparam int DEB_LONG_TK = DEB_LONG_MS * TICK_HZ / 1000;
  localparam int SETTLE_DIRECT_TK = SETTLE_DIRECT_MS * TICK_HZ / 1000;
  localparam int SETTLE_LEVEL_TK = SETTLE_LEVEL_MS * TICK_HZ / 1000;
  localparam int HF_STEP_HZ = 8192;
  localparam int HF_ACC_W = 32;
  // power states
  typedef enum logic [1:0] {bsw_main, bsw_backup, bsw_debounce} bsw_state_e;
endpackage

// *** rtl/bsw_ctrl.sv ***
// backup switchover and clock output control with apb register access
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
module bsw_ctrl
  import bsw_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC // cycles per low-frequency tick
)(
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic main_lt_backup, // comparator: main below backup
  input wire logic main_gt_level, // comparator: main above level threshold
  input wire logic backup_gt_level, // comparator: backup above level threshold
  input wire logic main_present, // comparator: main supply present
  input wire logic [5:0] clock_irq_events, // interrupt sources for clock path
  input wire logic xtal_clk, // raw crystal clock level
  input wire logic hf_clk_in, // high-frequency source level
  output logic backup_state, // running from backup supply
  output logic irq_n, // interrupt output, active low
  output logic serial_enable, // serial bus pins usable
  output logic serial_reset, // serial interface held in reset
  output logic event_input_enable, // external-event input enabled
  output logic backup_standby, // backup source in standby
  output logic charger_enable, // trickle charger on
  output logic charge_boost_allowed, // boosted charge levels allowed
  output logic compensate_enable, // output path compensated
  output logic clock_output_pin // clock output
);
  // ==========================================================================
  // synchronisers, three stages, change counted when stages two and three agree
  logic [3:0] s1, s2, s3, cmp;
  logic [1:0] c1, c2, c3;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
      cmp <= 4'h0;
    end
    else
    begin
      s1 <= {main_present, backup_gt_level, main_gt_level, main_lt_backup};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 4; i++)
        if (s2[i] == s3[i])
          cmp[i] <= s3[i];
    end
  end

  // clock sources are pins, synchronised through three stages without the agreement filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c1 <= 2'h0;
      c2 <= 2'h0;
      c3 <= 2'h0;
    end
    else
    begin
      c1 <= {hf_clk_in, xtal_clk};
      c2 <= c1;
      c3 <= c2;
    end
  end

  // ==========================================================================
  // registers
  logic [31:0] cfg, clkcfg;
  logic backup_switched_flag, irq_clock_path_flag;
  bsw_state_e state;
  logic wr_en;
  logic [1:0] mode;
  assign wr_en = psel && penable && pwrite;
  assign mode = cfg[CFG_MODE_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= CFG_RESET;
      clkcfg <= CLKCFG_RESET;
    end
    else if (wr_en && paddr == ADDR_CFG)
      cfg <= pwdata & CFG_WMASK;
    else if (wr_en && paddr == ADDR_CLKCFG)
      clkcfg <= {15'h0000, pwdata[16:0]};
  end

  // apb answers in one access cycle; unmapped addresses raise pslverr
  logic mapped;
  assign mapped = paddr == ADDR_CFG || paddr == ADDR_CLKCFG || paddr == ADDR_STATUS
    || paddr == ADDR_FLAGS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        ADDR_CFG: prdata <= cfg;
        ADDR_CLKCFG: prdata <= clkcfg;
        ADDR_STATUS: prdata <= {28'h0000000, backup_standby, serial_enable,
          state == bsw_debounce, backup_state};
        ADDR_FLAGS: prdata <= {30'h0, irq_clock_path_flag, backup_switched_flag};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // low-frequency tick
  logic [$clog2(TICK_DIV+1)-1:0] tdiv;
  logic tick;
  assign tick = tdiv == '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tdiv <= '0;
    else if (tick)
      tdiv <= ($clog2(TICK_DIV+1))'(TICK_DIV - 1);
    else
      tdiv <= tdiv - 1'b1;
  end

  // ==========================================================================
  // mode settle: after enabling a mode switching is held off for the settle time
  logic [1:0] mode_q;
  logic [10:0] settle;
  logic mode_on;
  assign mode_on = mode == MODE_DIRECT || mode == MODE_LEVEL;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= 2'h0;
      settle <= 11'h000;
    end
    else
    begin
      mode_q <= mode;
      if (mode != mode_q && mode == MODE_DIRECT)
        settle <= 11'(SETTLE_DIRECT_TK);
      else if (mode != mode_q && mode == MODE_LEVEL)
        settle <= 11'(SETTLE_LEVEL_TK);
      else if (tick && settle != 11'h000)
        settle <= settle - 11'h001;
    end
  end

  // switch decision
  logic want_backup;
  always_comb
  begin
    want_backup = 1'b0;
    if (!mode_on || settle != 11'h000)
      want_backup = 1'b0;
    else if (mode == MODE_DIRECT)
      want_backup = cmp[0];
    else if (cmp[1])
      want_backup = 1'b0;
    else if (cmp[2])
      want_backup = 1'b1;
    else
      want_backup = cmp[0];
  end

  // ==========================================================================
  // power state machine, evaluated on the tick
  logic [10:0] deb;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= bsw_main;
      deb <= 11'h000;
    end
    else if (tick)
    begin
      unique case (state)
        bsw_main:
          if (want_backup)
            state <= bsw_backup;
        bsw_backup:
          if (!want_backup)
          begin
            state <= bsw_debounce;
            deb <= cfg[CFG_VLF_BIT] ? 11'(DEB_LONG_TK) : 11'(DEB_SHORT_TK);
          end
        bsw_debounce:
          if (want_backup)
            state <= bsw_backup;
          else if (deb == 11'h000)
            state <= bsw_main;
          else
            deb <= deb - 11'h001;
      endcase
    end
  end

  // first power up from backup alone keeps backup in standby until main appears
  logic main_seen;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      main_seen <= 1'b0;
    else if (cmp[3])
      main_seen <= 1'b1;
  end
  assign backup_standby = !main_seen || !mode_on;

  assign backup_state = state == bsw_backup;
  assign serial_enable = state == bsw_main;
  assign serial_reset = state == bsw_backup;
  assign event_input_enable = state == bsw_main;

  // ==========================================================================
  // flags: set wins over clear; clears only accepted on main power
  logic clr_ok;
  assign clr_ok = wr_en && paddr == ADDR_FLAGS && state == bsw_main;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      backup_switched_flag <= 1'b0;
      irq_clock_path_flag <= 1'b0;
    end
    else
    begin
      if (tick && state == bsw_main && want_backup)
        backup_switched_flag <= 1'b1;
      else if (clr_ok && pwdata[FL_BSF_BIT])
        backup_switched_flag <= 1'b0;
      if (cfg[CFG_IRQ_CLOCK_PATH_ENABLE_BIT] && |(clock_irq_events & cfg[CFG_CLKMASK_LSB +: 6]))
        irq_clock_path_flag <= 1'b1;
      else if (clr_ok && pwdata[FL_IRQ_CLOCK_PATH_FLAG_BIT])
        irq_clock_path_flag <= 1'b0;
    end
  end
  assign irq_n = !(backup_switched_flag && cfg[CFG_IRQEN_BIT]);

  // ==========================================================================
  // trickle charger gating
  assign charger_enable = cfg[CFG_CHG_LSB +: 2] != CHG_OFF && mode_on
    && state == bsw_main;
  // boosted levels only offered while running from main, like the charger itself
  assign charge_boost_allowed = mode == MODE_LEVEL && cmp[1] && state == bsw_main;

  // ==========================================================================
  // clock output: crystal dividers and high-frequency accumulator
  logic xtal_prev;
  logic [14:0] xdiv;
  logic [HF_ACC_W-1:0] hf_acc;
  logic halt;
  assign halt = cfg[CFG_HALT_BIT];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xtal_prev <= 1'b0;
      xdiv <= 15'h0000;
      hf_acc <= '0;
    end
    else
    begin
      xtal_prev <= c3[0];
      if (c3[0] && !xtal_prev && !halt)
        xdiv <= xdiv + 15'h0001;
      // phase step = (hfd+1)*8192 / clk rate scaled to 2^32
      hf_acc <= hf_acc + HF_ACC_W'((64'(clkcfg[CC_HFD_LSB +: 13]) + 64'h1)
        * 64'(HF_STEP_HZ) * (64'h1 << HF_ACC_W) / 64'(CLK_HZ));
    end
  end

  // temperature compensation runs independent of power state
  logic sel_clk;
  always_comb
  begin
    sel_clk = 1'b0;
    compensate_enable = 1'b1;
    if (clkcfg[CC_OS_BIT])
    begin
      sel_clk = hf_acc[HF_ACC_W-1];
      compensate_enable = 1'b0;
    end
    else
    begin
      unique case (clkcfg[CC_FD_LSB +: 2])
        FD_RAW:
        begin
          sel_clk = c3[0];
          compensate_enable = 1'b0;
        end
        2'h1: sel_clk = xdiv[4];
        2'h2: sel_clk = xdiv[8];
        2'h3: sel_clk = xdiv[14];
      endcase
    end
  end

  logic clk_on;
  assign clk_on = !clkcfg[CC_DIS_BIT] || cfg[CFG_IRQ_CLOCK_PATH_ENABLE_BIT] || irq_clock_path_flag;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_output_pin <= 1'b0;
    else
      clock_output_pin <= sel_clk && clk_on && state == bsw_main;
  end
endmodule

// *** test/bsw_ctrl_assertions.sv ***
// port-level assertions for the switchover and clock output control
`timescale 1ns/10ps
module bsw_ctrl_chk
  import bsw_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC // cycles per low-frequency tick
)(
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic backup_state, // running from backup
  input wire logic serial_enable, // serial pins usable
  input wire logic serial_reset, // serial interface reset
  input wire logic event_input_enable, // event input enabled
  input wire logic backup_standby, // backup in standby
  input wire logic charger_enable, // charger on
  input wire logic charge_boost_allowed, // boosted levels allowed
  input wire logic clock_output_pin // clock output
);
  // ==========================================================================
  // apb and power state checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire access = psel && penable;
  wire unmapped = !(paddr inside {ADDR_CFG, ADDR_CLKCFG, ADDR_STATUS, ADDR_FLAGS});
  no_wait_a: assert property (access |-> pready) else $error("wait state seen");
  bad_addr_a: assert property (access |-> pslverr == unmapped) else $error("pslverr wrong");
  err_read_a: assert property (access && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  clk_low_a: assert property (backup_state [*2] |-> !clock_output_pin)
    else $error("clock pin active in backup");
  serial_off_a: assert property (backup_state |-> !serial_enable && serial_reset)
    else $error("serial port live in backup");
  event_off_a: assert property (backup_state |-> !event_input_enable)
    else $error("event input live in backup");
  charger_off_a: assert property (backup_state |-> !charger_enable)
    else $error("charger on in backup");
  boost_main_a: assert property (charge_boost_allowed |-> !backup_state)
    else $error("boost allowed in backup");
  return_deb_a: assert property ($fell(backup_state) |-> !serial_enable ##1 !serial_enable)
    else $error("serial back without debounce");
  serial_back_a: assert property ($rose(serial_enable)
    |-> !backup_state && $past(!backup_state))
    else $error("serial enabled in backup");
  standby_rst_a: assert property ($rose(presetn) |-> backup_standby)
    else $error("backup not in standby after reset");
endmodule
bind bsw_ctrl bsw_ctrl_chk #(.TICK_DIV(TICK_DIV)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .backup_state(backup_state),
  .serial_enable(serial_enable), .serial_reset(serial_reset),
  .event_input_enable(event_input_enable), .backup_standby(backup_standby),
  .charger_enable(charger_enable), .charge_boost_allowed(charge_boost_allowed),
  .clock_output_pin(clock_output_pin));

// *** test/bsw_supply_model.sv ***
// supply comparator model standing in for the analog side
`timescale 1ns/10ps
module bsw_supply_model #(
  parameter int LEVEL_MV = 2000 // level threshold, typical value
)(
  input wire logic pclk, // clock
  input var int vdd_mv, // main supply in millivolts
  input var int vbat_mv, // backup supply in millivolts
  output logic main_lt_backup, // main below backup
  output logic main_gt_level, // main above threshold
  output logic backup_gt_level, // backup above threshold
  output logic main_present // main supply present
);
  // comparators resample each clock and change just after the edge
  always @(posedge pclk)
  begin
    main_lt_backup <= vdd_mv < vbat_mv;
    main_gt_level <= vdd_mv > LEVEL_MV;
    backup_gt_level <= vbat_mv > LEVEL_MV;
    main_present <= vdd_mv > 1400;
  end
endmodule

// *** test/test_bsw_ctrl.sv ***
// self-checking bench for the switchover and clock output control
`timescale 1ns/10ps
module test_bsw_ctrl;
  import bsw_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] irq_ev = 6'h00;
  logic pready, pslverr, lt, gm, gb, mp, xtal_clk = 0, hf_clk_in = 0;
  logic backup_state, irq_n, serial_enable, serial_reset, event_input_enable, backup_standby;
  logic charger_enable, charge_boost_allowed, compensate_enable, clock_output_pin;
  int vdd_mv = 3300, vbat_mv = 0, mismatches = 0, total_checks = 0, cyc = 0, waited, hi;
  bsw_supply_model i_bsw_supply_model (.pclk(pclk), .vdd_mv(vdd_mv), .vbat_mv(vbat_mv),
    .main_lt_backup(lt), .main_gt_level(gm), .backup_gt_level(gb), .main_present(mp));
  bsw_ctrl #(.TICK_DIV(4)) i_bsw_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_lt_backup(lt), .main_gt_level(gm),
    .backup_gt_level(gb), .main_present(mp), .clock_irq_events(irq_ev), .xtal_clk(xtal_clk),
    .hf_clk_in(hf_clk_in), .backup_state(backup_state), .irq_n(irq_n),
    .serial_enable(serial_enable), .serial_reset(serial_reset),
    .event_input_enable(event_input_enable), .backup_standby(backup_standby),
    .charger_enable(charger_enable), .charge_boost_allowed(charge_boost_allowed),
    .compensate_enable(compensate_enable), .clock_output_pin(clock_output_pin));
  // ==========================================================================
  // clock, source clocks and timeout
  initial forever #20 pclk = ~pclk;
  // source clocks from a cycle count, cut short on a hang
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    xtal_clk <= cyc[4];
    hf_clk_in <= cyc[1];
    if (cyc == 40000)
    begin
      mismatches++;
      end_sim();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, entered just after an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wait for backup_state (s 0) or serial_enable (s 1) to reach v
  task automatic wait_for(input int s, input logic v);
    waited = 0;
    while (((s == 0) ? backup_state : serial_enable) !== v && waited < 6000)
    begin
      @(posedge pclk);
      waited++;
    end
    chk("wait", 32'h1, 32'(waited < 6000));
  endtask
  // count high cycles of the clock pin over a window
  task automatic count_hi();
    hi = 0;
    repeat (200)
    begin
      @(posedge pclk);
      hi += int'(clock_output_pin === 1'b1);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg", CFG_RESET, rd);
    apb(1'b0, ADDR_CLKCFG, 32'h0);
    chk("clkcfg", CLKCFG_RESET, rd);
    chk("irq_n", 1'b1, irq_n);
    chk("standby", 1'b1, backup_standby);
    chk("raw_nocomp", 1'b0, compensate_enable);
    count_hi();
    chk("raw_toggle", 1'b1, hi > 0 && hi < 200);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 1'b1, err);
    chk("unmapped_rd", 32'h0, rd);
    $display("done reset");
  endtask
  task automatic t_disabled();
    vdd_mv <= 1500;
    vbat_mv <= 3000;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, ADDR_CFG, 32'h14 | (i * 3));
      repeat (100) @(posedge pclk);
      chk("no_switch", 1'b0, backup_state);
      chk("charger_dis", 1'b0, charger_enable);
    end
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("bsf_zero", 32'h0, rd & 32'h1);
    $display("done disabled");
  endtask
  task automatic t_direct();
    vdd_mv <= 3300;
    apb(1'b1, ADDR_CFG, 32'h15);
    repeat (60) @(posedge pclk);
    chk("charger_on", 1'b1, charger_enable);
    chk("standby_off", 1'b0, backup_standby);
    vdd_mv <= 2800;
    wait_for(0, 1'b1);
    chk("irq_low", 1'b0, irq_n);
    chk("serial_rst", 1'b1, serial_reset);
    chk("event_off", 1'b0, event_input_enable);
    @(posedge pclk);
    chk("clk_low", 1'b0, clock_output_pin);
    apb(1'b1, ADDR_FLAGS, 32'h1);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("bsf_held", 32'h1, rd & 32'h1);
    vdd_mv <= 3300;
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    chk("short_deb", 1'b1, waited < 40);
    chk("irq_kept", 1'b0, irq_n);
    apb(1'b1, ADDR_FLAGS, 32'h1);
    chk("irq_clear", 1'b1, irq_n);
    $display("done direct");
  endtask
  task automatic t_level();
    apb(1'b1, ADDR_CFG, 32'h72);
    repeat (100) @(posedge pclk);
    chk("boost_on", 1'b1, charge_boost_allowed);
    vdd_mv <= 2500;
    repeat (100) @(posedge pclk);
    chk("main_kept", 1'b0, backup_state);
    vdd_mv <= 1800;
    vbat_mv <= 1500;
    repeat (100) @(posedge pclk);
    chk("fallback", 1'b0, backup_state);
    chk("boost_off", 1'b0, charge_boost_allowed);
    vbat_mv <= 3000;
    wait_for(0, 1'b1);
    vdd_mv <= 3300;
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    chk("long_deb", 1'b1, waited > 3000);
    $display("done level");
  endtask
  task automatic t_clock_output_pin();
    apb(1'b1, ADDR_CLKCFG, 32'h8);
    count_hi();
    chk("disabled_low", 32'h0, hi);
    apb(1'b1, ADDR_CLKCFG, 32'h1);
    chk("div_comp", 1'b1, compensate_enable);
    apb(1'b1, ADDR_CFG, 32'h4072);
    count_hi();
    chk("halted", 1'b1, hi == 0 || hi == 200);
    apb(1'b1, ADDR_CLKCFG, 32'hff4);
    chk("hf_nocomp", 1'b0, compensate_enable);
    count_hi();
    chk("hf_toggle", 1'b1, hi > 0 && hi < 200);
    $display("done clock_output_pin");
  endtask
  // masked event in backup latches the clock path flag, clock shows on main only
  task automatic t_irqclk();
    apb(1'b1, ADDR_CLKCFG, 32'h8);
    apb(1'b1, ADDR_CFG, 32'h181);
    vdd_mv <= 2800;
    wait_for(0, 1'b1);
    irq_ev <= 6'h01;
    @(posedge pclk);
    irq_ev <= 6'h00;
    repeat (2) @(posedge pclk);
    chk("clk_backup", 1'b0, clock_output_pin);
    vdd_mv <= 3300;
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    apb(1'b1, ADDR_CFG, 32'h101);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("irq_clock_path_flag_set", 32'h2, rd & 32'h2);
    count_hi();
    chk("irq_clock", 1'b1, hi > 0 && hi < 200);
    apb(1'b1, ADDR_FLAGS, 32'h2);
    count_hi();
    chk("irq_clock_path_flag_off", 32'h0, hi);
    $display("done irqclk");
  endtask
  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_disabled();
    t_direct();
    t_level();
    t_clock_output_pin();
    t_irqclk();
    end_sim();
  end
endmodule
